// >>> hdl/exc_pkg.sv
// constants, layouts and carriers for the exception entry unit
package exc_pkg;

  // -------------------------------------------------------------------
  // bus and register map (indices; byte address is four times)
  // -------------------------------------------------------------------
  localparam int unsigned WB_ADR_W = 18;
  localparam logic [15:0] IDX_SYSTEM_CONTROL = 16'hFFF2;
  localparam logic [15:0] IDX_SENSE_SELECT   = 16'hFFF4;
  localparam logic [15:0] IDX_REQUEST_ENABLE = 16'hFFF5;
  localparam logic [15:0] IDX_REQUEST_FLAGS  = 16'hFFF6;
  localparam logic [15:0] IDX_PRIORITY_A     = 16'hFFF8;
  localparam logic [15:0] IDX_PRIORITY_B     = 16'hFFF9;

  localparam logic [7:0] RST_SYSTEM_CONTROL = 8'h0B;
  localparam logic [7:0] RST_REG_ZERO       = 8'h00;
  localparam logic [7:0] FLAGS_USED_MASK    = 8'h33;

  localparam int unsigned USER_BIT_SELECT_POS  = 3;
  localparam int unsigned NONMASK_EDGE_SEL_POS = 2;

  // -------------------------------------------------------------------
  // vectors and sources
  // -------------------------------------------------------------------
  localparam int unsigned VEC_W   = 6;
  localparam int unsigned VEC_NUM = 64;
  localparam int unsigned ADR_W   = 24;
  localparam logic [5:0] VEC_RESET = 6'h00;
  localparam logic [5:0] VEC_NMI   = 6'h07;
  localparam logic [5:0] VEC_TRAP0 = 6'h08;
  localparam int unsigned VEC_INT0 = 20;
  localparam int unsigned INT_SRC  = 25;
  localparam int unsigned EXT_NUM  = 4;
  // lines 0, 1, 4, 5: vector, flag bit, level bit in priority_level_a
  localparam logic [5:0]  EXT_VEC [EXT_NUM] = '{6'h0C, 6'h0D, 6'h10, 6'h11};
  localparam int unsigned EXT_POS [EXT_NUM] = '{0, 1, 4, 5};
  localparam int unsigned EXT_PRI [EXT_NUM] = '{7, 6, 4, 4};

  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int unsigned CLK_HZ            = 25_000_000;
  localparam int unsigned RUN_RESET_MIN_CYC = 10;
  localparam logic [3:0]  WDT_RESET_CYC     = 4'(RUN_RESET_MIN_CYC);

  // -------------------------------------------------------------------
  // core carriers
  // -------------------------------------------------------------------
  typedef struct packed {
    logic             insn_done;
    logic             trap_exec;
    logic [1:0]       trap_num;
    logic             entry_ack;
    logic             flag_i;
    logic             flag_ui;
    logic [ADR_W-1:0] stack_ptr;
  } core_to_exc_s;

  typedef struct packed {
    logic             hold_core;
    logic             periph_reset;
    logic             entry_req;
    logic [VEC_W-1:0] vector_num;
    logic [ADR_W-1:0] vector_addr;
    logic             push_frame;
    logic             set_i;
    logic             set_ui;
    logic [ADR_W-1:0] frame_addr;
  } exc_to_core_s;

endpackage

// >>> hdl/lowest_pick.sv
// finds the lowest set bit of a request vector
`timescale 1ns/1ps
module lowest_pick #(
  parameter int unsigned WIDTH = 64
) (
  input  wire logic [WIDTH-1:0]         req,
  output logic                          found,
  output logic [$clog2(WIDTH)-1:0]      idx
);

  always_comb begin
    found = 1'b0;
    idx   = '0;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        idx   = ($clog2(WIDTH))'(i);
      end
    end
  end

endmodule

// >>> hdl/pin_sync_edge.sv
// two-stage pin synchroniser with edge detection
`timescale 1ns/1ps
module pin_sync_edge #(
  parameter int unsigned      WIDTH = 1,
  parameter logic [WIDTH-1:0] IDLE  = '1
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
  } sync_s;

  sync_s s;
  sync_s next_s;

  always_comb begin
    next_s    = s;
    next_s.s1 = pin_in;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s <= '{s1: IDLE, s2: IDLE, s3: IDLE};
    end else begin
      s <= next_s;
    end
  end

  assign level = s.s2;
  assign rise  = s.s2 & ~s.s3;
  assign fall  = ~s.s2 & s.s3;

endmodule

// >>> hdl/reset_trap_interrupt_entry.sv
// reset, trap and interrupt entry unit with its register file
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
module reset_trap_interrupt_entry (
  input  wire logic                          ref_clk,
  input  wire logic                          rstn,
  input  wire logic                          chip_init_pin_n,
  input  wire logic                          nmi_pin,
  input  wire logic                          ext_line_0,
  input  wire logic                          ext_line_1,
  input  wire logic                          ext_line_4,
  input  wire logic                          ext_line_5,
  input  wire logic [exc_pkg::INT_SRC-1:0]   periph_req,
  input  wire logic                          wdt_overflow,
  input  wire exc_pkg::core_to_exc_s         core_in,
  output exc_pkg::exc_to_core_s              core_out,
  input  wire logic [exc_pkg::WB_ADR_W-1:0]  adr_i,
  input  wire logic [31:0]                   dat_i,
  input  wire logic [3:0]                    sel_i,
  input  wire logic                          we_i,
  input  wire logic                          cyc_i,
  input  wire logic                          stb_i,
  output logic [31:0]                        dat_o,
  output logic                               ack_o
);

  typedef enum logic [2:0] {
    ST_RESET,
    ST_VEC_FETCH,
    ST_FIRST_INSN,
    ST_RUN,
    ST_ENTRY
  } state_e;

  typedef struct packed {
    state_e                st;
    logic [3:0]            wdt_cnt;
    logic                  ack;
    logic [7:0]            rdata;
    logic [7:0]            system_control;
    logic [7:0]            ext_request_sense_select;
    logic [7:0]            ext_request_enable;
    logic [7:0]            ext_request_flags;
    logic [7:0]            priority_level_a;
    logic [7:0]            priority_level_b;
    logic                  nmi_pend;
    exc_pkg::exc_to_core_s out;
  } state_s;

  localparam state_s S_INIT = '{
    st:      ST_RESET,
    system_control:   exc_pkg::RST_SYSTEM_CONTROL,
    ext_request_sense_select:    exc_pkg::RST_REG_ZERO,
    ext_request_enable:     exc_pkg::RST_REG_ZERO,
    ext_request_flags:     exc_pkg::RST_REG_ZERO,
    priority_level_a:    exc_pkg::RST_REG_ZERO,
    priority_level_b:    exc_pkg::RST_REG_ZERO,
    out:     '{hold_core: 1'b1, periph_reset: 1'b1, default: '0},
    default: '0
  };

  state_s s;
  state_s next_s;

  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  function automatic logic [exc_pkg::ADR_W-1:0] even_addr(
    input logic [exc_pkg::ADR_W-1:0] a
  );
    even_addr = {a[exc_pkg::ADR_W-1:1], 1'b0};
  endfunction

  function automatic exc_pkg::exc_to_core_s make_entry(
    input logic [5:0]                vec,
    input logic                      push,
    input logic                      ui,
    input logic [exc_pkg::ADR_W-1:0] sp
  );
    exc_pkg::exc_to_core_s e;
    e              = '0;
    e.entry_req    = 1'b1;
    e.vector_num   = vec;
    // advanced mode: four bytes per vector entry
    e.vector_addr  = even_addr({16'h0000, vec, 2'b00});
    e.push_frame   = push;
    e.set_i        = 1'b1;
    e.set_ui       = ui;
    e.frame_addr   = even_addr(sp);
    make_entry     = e;
  endfunction

  // module groups of internal sources and their level bits
  function automatic logic int_level(
    input int unsigned k,
    input logic [7:0]  pa,
    input logic [7:0]  pb
  );
    if (k == 0) begin
      int_level = pa[3];
    end else if (k <= 3) begin
      int_level = pa[2];
    end else if (k <= 6) begin
      int_level = pa[1];
    end else if (k <= 9) begin
      int_level = pa[0];
    end else if (k <= 12) begin
      int_level = pb[7];
    end else if (k <= 15) begin
      int_level = pb[6];
    end else if (k <= 19) begin
      int_level = pb[3];
    end else if (k <= 23) begin
      int_level = pb[2];
    end else begin
      int_level = pb[1];
    end
  endfunction

  // -------------------------------------------------------------------
  // pins
  // -------------------------------------------------------------------
  logic [5:0] pin_lvl;
  logic [5:0] pin_rise;
  logic [5:0] pin_fall;

  pin_sync_edge #(
    .WIDTH (6),
    .IDLE  (6'h1F)
  ) u_pins (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .pin_in  ({chip_init_pin_n, nmi_pin, ext_line_5, ext_line_4,
               ext_line_1, ext_line_0}),
    .level   (pin_lvl),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  logic held;
  logic ue;
  logic nmi_edge;

  // init pin low, or a watchdog reset still running
  assign held = ~pin_lvl[5] | (s.wdt_cnt != 4'h0) | wdt_overflow;
  assign ue   = s.system_control[exc_pkg::USER_BIT_SELECT_POS];
  assign nmi_edge = s.system_control[exc_pkg::NONMASK_EDGE_SEL_POS] ?
                    pin_rise[4] : pin_fall[4];

  // -------------------------------------------------------------------
  // request arbitration
  // -------------------------------------------------------------------
  logic [exc_pkg::VEC_NUM-1:0] req_all;
  logic [exc_pkg::VEC_NUM-1:0] lvl1;
  logic [exc_pkg::VEC_NUM-1:0] req_hi;
  logic [exc_pkg::VEC_NUM-1:0] req_lo;
  logic                        allow_hi;
  logic                        allow_lo;
  logic                        hi_found;
  logic                        lo_found;
  logic [5:0]                  hi_idx;
  logic [5:0]                  lo_idx;
  logic                        take;
  logic [5:0]                  take_vec;

  always_comb begin
    req_all = '0;
    lvl1    = '0;
    for (int j = 0; j < exc_pkg::EXT_NUM; j++) begin
      req_all[exc_pkg::EXT_VEC[j]] = s.ext_request_flags[exc_pkg::EXT_POS[j]] &
                                     s.ext_request_enable[exc_pkg::EXT_POS[j]];
      lvl1[exc_pkg::EXT_VEC[j]]    = s.priority_level_a[exc_pkg::EXT_PRI[j]];
    end
    for (int k = 0; k < exc_pkg::INT_SRC; k++) begin
      req_all[exc_pkg::VEC_INT0 + k] = periph_req[k];
      lvl1[exc_pkg::VEC_INT0 + k]    = int_level(k, s.priority_level_a, s.priority_level_b);
    end
  end

  // user bit plain when select is 1, extra mask when 0
  assign allow_lo = ~core_in.flag_i;
  assign allow_hi = ~core_in.flag_i | (~ue & ~core_in.flag_ui);
  assign req_hi   = req_all & lvl1 & {exc_pkg::VEC_NUM{allow_hi}};
  assign req_lo   = req_all & ~lvl1 & {exc_pkg::VEC_NUM{allow_lo}};

  lowest_pick #(
    .WIDTH (exc_pkg::VEC_NUM)
  ) u_pick_hi (
    .req   (req_hi),
    .found (hi_found),
    .idx   (hi_idx)
  );

  lowest_pick #(
    .WIDTH (exc_pkg::VEC_NUM)
  ) u_pick_lo (
    .req   (req_lo),
    .found (lo_found),
    .idx   (lo_idx)
  );

  // nonmaskable first, then level 1, then level 0, lowest vector first
  always_comb begin
    take     = s.nmi_pend | hi_found | lo_found;
    take_vec = s.nmi_pend ? exc_pkg::VEC_NMI :
               hi_found   ? hi_idx : lo_idx;
  end

  // -------------------------------------------------------------------
  // register file, flags and entry sequencer
  // -------------------------------------------------------------------
  logic        bus_req;
  logic        bus_wr;
  logic [15:0] bus_idx;
  logic [7:0]  wbyte;
  logic [7:0]  rd_val;

  assign bus_req = cyc_i & stb_i & ~s.ack;
  assign bus_wr  = bus_req & we_i & sel_i[0];
  assign bus_idx = adr_i[exc_pkg::WB_ADR_W-1:2];
  assign wbyte   = dat_i[7:0];

  always_comb begin
    unique case (bus_idx)
      exc_pkg::IDX_SYSTEM_CONTROL: rd_val = s.system_control;
      exc_pkg::IDX_SENSE_SELECT:   rd_val = s.ext_request_sense_select;
      exc_pkg::IDX_REQUEST_ENABLE: rd_val = s.ext_request_enable;
      exc_pkg::IDX_REQUEST_FLAGS:  rd_val = s.ext_request_flags;
      exc_pkg::IDX_PRIORITY_A:     rd_val = s.priority_level_a;
      exc_pkg::IDX_PRIORITY_B:     rd_val = s.priority_level_b;
      default:                     rd_val = 8'h00;
    endcase
  end

  always_comb begin
    next_s     = s;
    next_s.ack = bus_req;
    if (bus_req && !we_i) begin
      next_s.rdata = rd_val;
    end
    if (wdt_overflow) begin
      next_s.wdt_cnt = exc_pkg::WDT_RESET_CYC;
    end else if (s.wdt_cnt != 4'h0) begin
      next_s.wdt_cnt = s.wdt_cnt - 4'h1;
    end

    if (bus_wr) begin
      unique case (bus_idx)
        exc_pkg::IDX_SYSTEM_CONTROL: next_s.system_control = wbyte;
        exc_pkg::IDX_SENSE_SELECT:   next_s.ext_request_sense_select  = wbyte;
        exc_pkg::IDX_REQUEST_ENABLE: next_s.ext_request_enable   = wbyte;
        exc_pkg::IDX_REQUEST_FLAGS:  next_s.ext_request_flags   = s.ext_request_flags & wbyte;
        exc_pkg::IDX_PRIORITY_A:     next_s.priority_level_a  = wbyte;
        exc_pkg::IDX_PRIORITY_B:     next_s.priority_level_b  = wbyte;
        default:                     next_s.priority_level_b  = s.priority_level_b;
      endcase
    end

    unique case (s.st)
      ST_RESET: begin
        // only reached once held has dropped: the release edge
        next_s.out = make_entry(exc_pkg::VEC_RESET, 1'b0, 1'b0,
                                core_in.stack_ptr);
        next_s.st  = ST_VEC_FETCH;
      end
      ST_VEC_FETCH: begin
        if (core_in.entry_ack) begin
          next_s.out.entry_req = 1'b0;
          next_s.st            = ST_FIRST_INSN;
        end
      end
      ST_FIRST_INSN, ST_RUN: begin
        if (core_in.trap_exec) begin
          next_s.out = make_entry(exc_pkg::VEC_TRAP0 +
                                  {4'h0, core_in.trap_num}, 1'b1, ~ue,
                                  core_in.stack_ptr);
          next_s.st  = ST_ENTRY;
        end else if (core_in.insn_done && s.st == ST_FIRST_INSN) begin
          next_s.st = ST_RUN;
        end else if (core_in.insn_done && take) begin
          next_s.out = make_entry(take_vec, 1'b1, ~ue,
                                  core_in.stack_ptr);
          next_s.st  = ST_ENTRY;
          if (take_vec == exc_pkg::VEC_NMI) begin
            next_s.nmi_pend = 1'b0;
          end
          for (int j = 0; j < exc_pkg::EXT_NUM; j++) begin
            if (take_vec == exc_pkg::EXT_VEC[j]) begin
              next_s.ext_request_flags[exc_pkg::EXT_POS[j]] = 1'b0;
            end
          end
        end
      end
      ST_ENTRY: begin
        if (core_in.entry_ack) begin
          next_s.out.entry_req = 1'b0;
          next_s.st            = ST_RUN;
        end
      end
      default: begin
        next_s.st = ST_RESET;
      end
    endcase

    // set wins over software and acceptance clears
    for (int j = 0; j < exc_pkg::EXT_NUM; j++) begin
      if (s.ext_request_sense_select[exc_pkg::EXT_POS[j]] ? pin_fall[j] : ~pin_lvl[j]) begin
        next_s.ext_request_flags[exc_pkg::EXT_POS[j]] = 1'b1;
      end
    end
    next_s.ext_request_flags = next_s.ext_request_flags & exc_pkg::FLAGS_USED_MASK;
    if (nmi_edge) begin
      next_s.nmi_pend = 1'b1;
    end

    if (held) begin
      next_s         = S_INIT;
      next_s.wdt_cnt = wdt_overflow ? exc_pkg::WDT_RESET_CYC :
                       (s.wdt_cnt != 4'h0) ? s.wdt_cnt - 4'h1 : 4'h0;
      next_s.ack     = bus_req;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s <= S_INIT;
    end else begin
      s <= next_s;
    end
  end

  assign core_out = s.out;
  assign ack_o    = s.ack;
  assign dat_o    = {24'h000000, s.rdata};

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  property p_hold_in_reset;
    @(posedge ref_clk) disable iff (!rstn)
    !pin_lvl[5] |=> core_out.hold_core && !core_out.entry_req;
  endproperty
  a_hold_in_reset: assert property (p_hold_in_reset)
    else $error("core not held while init pin low");

  property p_start_on_release;
    @(posedge ref_clk) disable iff (!rstn)
    s.st == ST_RESET && !held |=> core_out.entry_req &&
      core_out.vector_num == exc_pkg::VEC_RESET &&
      core_out.vector_addr == 24'h000000 && !core_out.hold_core;
  endproperty
  a_start_on_release: assert property (p_start_on_release)
    else $error("reset vector fetch not started on release");

  property p_wdt_reset;
    @(posedge ref_clk) disable iff (!rstn)
    wdt_overflow |=> core_out.hold_core [*8];
  endproperty
  a_wdt_reset: assert property (p_wdt_reset)
    else $error("watchdog overflow did not hold reset");

  property p_reset_entry_mask;
    @(posedge ref_clk) disable iff (!rstn)
    $rose(core_out.entry_req) && s.st == ST_VEC_FETCH |->
      core_out.set_i && !core_out.push_frame && s.system_control == 8'h0B;
  endproperty
  a_reset_entry_mask: assert property (p_reset_entry_mask)
    else $error("reset entry without mask set or defaults");

  property p_first_insn_guard;
    @(posedge ref_clk) disable iff (!rstn)
    s.st == ST_FIRST_INSN && !core_in.trap_exec && !held |=>
      !core_out.entry_req;
  endproperty
  a_first_insn_guard: assert property (p_first_insn_guard)
    else $error("interrupt entered before first instruction");

  property p_nmi_first;
    @(posedge ref_clk) disable iff (!rstn)
    s.st == ST_RUN && core_in.insn_done && !core_in.trap_exec &&
      s.nmi_pend && !held |=> core_out.entry_req &&
      core_out.vector_num == exc_pkg::VEC_NMI && core_out.push_frame;
  endproperty
  a_nmi_first: assert property (p_nmi_first)
    else $error("pending nonmaskable request not taken");

  property p_mask_all;
    @(posedge ref_clk) disable iff (!rstn)
    s.st == ST_RUN && core_in.insn_done && !core_in.trap_exec &&
      !s.nmi_pend && core_in.flag_i && (ue || core_in.flag_ui) |=>
      s.st != ST_ENTRY;
  endproperty
  a_mask_all: assert property (p_mask_all)
    else $error("masked interrupt accepted");

  property p_level_order;
    @(posedge ref_clk) disable iff (!rstn)
    s.st == ST_RUN && core_in.insn_done && !core_in.trap_exec &&
      !s.nmi_pend && hi_found && !held |=>
      core_out.vector_num == $past(hi_idx);
  endproperty
  a_level_order: assert property (p_level_order)
    else $error("high level request lost arbitration");

  property p_trap_vector;
    @(posedge ref_clk) disable iff (!rstn)
    (s.st == ST_RUN || s.st == ST_FIRST_INSN) && core_in.trap_exec &&
      !held |=> core_out.entry_req && core_out.set_i &&
      core_out.set_ui == !ue && core_out.vector_addr[1:0] == 2'b00 &&
      core_out.vector_num == 6'(8 + $past(core_in.trap_num));
  endproperty
  a_trap_vector: assert property (p_trap_vector)
    else $error("trap entry vector or mask wrong");

endmodule

// >>> test/pin_partner.sv
// model of the external init pin and request lines
`timescale 1ns/1ps
module pin_partner #(
  parameter int unsigned POWER_UP_CYC = 20,
  parameter int unsigned RUN_CYC      = 10
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_req,
  input  wire logic       nmi_lvl,
  input  wire logic [3:0] ext_lvl,
  output logic            chip_init_pin_n,
  output logic            nmi_pin,
  output logic [3:0]      ext_pins
);
  // power-up hold shortened to a cycle count
  int unsigned low_cnt = POWER_UP_CYC;
  always @(posedge ref_clk) begin
    if (rst_req)
      low_cnt <= RUN_CYC;
    else if (low_cnt != 0)
      low_cnt <= low_cnt - 1;
  end
  assign chip_init_pin_n = (low_cnt == 0);
  // lines follow the bench levels directly, which idle high
  assign nmi_pin  = nmi_lvl;
  assign ext_pins = ext_lvl;
endmodule

// >>> test/tb_top.sv
// self-checking bench for the exception entry unit
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 0, rstn = 0, rst_req = 0, nmi_lvl = 1, wdt = 0;
  logic [3:0]  ext_lvl = 4'hF;
  logic        init_n, nmi_pin, we = 0, cyc = 0, ack;
  logic [3:0]  ext_pins;
  logic [24:0] preq = '0;
  logic [17:0] adr = '0;
  logic [31:0] dat = '0, dat_o;
  logic [57:0] en_q[$], e, g;
  logic [7:0]  rd_q[$];
  logic [1:0]  n;
  int          fail_count = 0, n_checks = 0, seed = 85;
  exc_pkg::core_to_exc_s ci = '0;
  exc_pkg::exc_to_core_s co;

  always #20 ref_clk = ~ref_clk;

  pin_partner u_pin_partner (.ref_clk, .rst_req, .nmi_lvl, .ext_lvl,
    .chip_init_pin_n(init_n), .nmi_pin, .ext_pins);
  reset_trap_interrupt_entry u_reset_trap_interrupt_entry (.ref_clk,
    .rstn, .chip_init_pin_n(init_n), .nmi_pin,
    .ext_line_0(ext_pins[0]), .ext_line_1(ext_pins[1]),
    .ext_line_4(ext_pins[2]), .ext_line_5(ext_pins[3]),
    .periph_req(preq), .wdt_overflow(wdt), .core_in(ci), .core_out(co),
    .adr_i(adr), .dat_i(dat), .sel_i(4'hF), .we_i(we), .cyc_i(cyc),
    .stb_i(cyc), .dat_o, .ack_o(ack));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  function automatic logic [57:0] ex(input logic [5:0] v, input logic p,
                                     input logic u, input logic [23:0] s);
    return {p, v, 16'h0000, v, 2'b00, p, 1'b1, u, s & 24'hFFFFFE};
  endfunction

  task automatic wb(input logic [15:0] idx, input logic w,
                    input logic [7:0] d);
    int t = 0;
    if (!w)
      rd_q.push_back(d);
    cyc <= 1;
    we  <= w;
    adr <= {idx, 2'b00};
    dat <= {24'h000000, d};
    do @(posedge ref_clk); while (ack !== 1'b1 && ++t < 50);
    if (ack !== 1'b1)
      fail_count++;
    cyc <= 0;
    @(posedge ref_clk);
  endtask

  task automatic insn;
    // leaves room for the pin synchroniser and pending edge flags
    repeat (4) @(posedge ref_clk);
    ci.insn_done <= 1;
    @(posedge ref_clk);
    ci.insn_done <= 0;
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic take(input logic [57:0] x);
    int t = 0;
    en_q.push_back(x);
    while (co.entry_req !== 1'b1 && t++ < 60) @(posedge ref_clk);
    if (co.entry_req !== 1'b1)
      fail_count++;
    ci.entry_ack <= 1;
    @(posedge ref_clk);
    ci.entry_ack <= 0;
    @(posedge ref_clk);
  endtask

  // -------------------------------------------------------------------
  // result monitor
  // -------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (ack === 1'b1 && !we && rd_q.size() > 0)
      chk(dat_o, {24'h000000, rd_q.pop_front()});
    if (co.entry_req === 1'b1 && en_q.size() > 0) begin
      e = en_q.pop_front();
      g = {e[57], co.vector_num, co.vector_addr, co.push_frame, co.set_i,
           co.set_ui, co.frame_addr};
      if (!e[57])
        g[23:0] = e[23:0];
      chk(g, e);
    end
  end

  initial begin
    #400000;
    fail_count++;
    wrap_up;
  end

  initial begin
    ci.stack_ptr = 24'($random(seed)) | 24'h000001;
    repeat (2) @(posedge ref_clk);
    rstn <= 1;
    take(ex(exc_pkg::VEC_RESET, 0, 0, 0));
    wb(exc_pkg::IDX_SYSTEM_CONTROL, 0, 8'h0B);
    wb(exc_pkg::IDX_PRIORITY_B, 0, 8'h00);
    wb(16'h1234, 1, 8'h5A);
    wb(16'h1234, 0, 8'h00);
    wb(exc_pkg::IDX_REQUEST_ENABLE, 1, 8'h01);
    ext_lvl[0] <= 0;
    insn;
    chk(co.entry_req, 0);
    insn;
    take(ex(6'h0C, 1, 0, ci.stack_ptr));
    ext_lvl[0] <= 1;
    // level flag keeps setting until the synchronised line is high
    repeat (4) @(posedge ref_clk);
    wb(exc_pkg::IDX_REQUEST_FLAGS, 1, 8'h00);
    wb(exc_pkg::IDX_SENSE_SELECT, 1, 8'h02);
    ext_lvl[1] <= 0;
    repeat (4) @(posedge ref_clk);
    ext_lvl[1] <= 1;
    wb(exc_pkg::IDX_REQUEST_FLAGS, 0, 8'h02);
    wb(exc_pkg::IDX_REQUEST_FLAGS, 1, 8'hFF);
    wb(exc_pkg::IDX_REQUEST_FLAGS, 0, 8'h02);
    wb(exc_pkg::IDX_REQUEST_FLAGS, 1, 8'h00);
    wb(exc_pkg::IDX_REQUEST_FLAGS, 0, 8'h00);
    wb(exc_pkg::IDX_SYSTEM_CONTROL, 1, 8'h03);
    for (int k = 0; k < 4; k++) begin
      n = 2'(k);
      ci.stack_ptr <= 24'($random(seed));
      ci.trap_num  <= n;
      ci.trap_exec <= 1;
      @(posedge ref_clk);
      ci.trap_exec <= 0;
      take(ex(6'(exc_pkg::VEC_TRAP0 + n), 1, 1, ci.stack_ptr));
    end
    ci.flag_i <= 1;
    wb(exc_pkg::IDX_PRIORITY_A, 1, 8'h04);
    preq <= 25'h0000003;
    insn;
    take(ex(6'd21, 1, 1, ci.stack_ptr));
    preq <= 25'h0000011;
    ci.flag_ui <= 1;
    insn;
    chk(co.entry_req, 0);
    nmi_lvl <= 0;
    insn;
    take(ex(exc_pkg::VEC_NMI, 1, 1, ci.stack_ptr));
    ci.flag_i  <= 0;
    ci.flag_ui <= 0;
    insn;
    take(ex(6'd20, 1, 1, ci.stack_ptr));
    preq <= '0;
    wdt  <= 1;
    @(posedge ref_clk);
    wdt <= 0;
    repeat (3) @(posedge ref_clk);
    chk(co.hold_core, 1);
    chk(co.periph_reset, 1);
    take(ex(exc_pkg::VEC_RESET, 0, 0, 0));
    wb(exc_pkg::IDX_SYSTEM_CONTROL, 0, 8'h0B);
    rst_req <= 1;
    @(posedge ref_clk);
    rst_req <= 0;
    repeat (8) @(posedge ref_clk);
    chk(co.hold_core, 1);
    take(ex(exc_pkg::VEC_RESET, 0, 0, 0));
    wrap_up;
  end
endmodule
